/* File: design/hsp_pkg.sv */
package hsp_pkg;

  // =====================================================================
  // strap encodings
  localparam logic SERIAL_MODE_I2C   = 1'b1;
  localparam logic SERIAL_MODE_SMBUS = 1'b0;
  localparam logic POL_ACTIVE_LOW    = 1'b0;
  localparam logic POL_ACTIVE_HIGH   = 1'b1;
  localparam logic POWER_INDIVIDUAL  = 1'b0;
  localparam logic POWER_GANGED      = 1'b1;

  // =====================================================================
  // widths and reset values
  localparam int            PORT_COUNT     = 4;
  localparam int            CONFIG_WIDTH   = 2;
  localparam logic          STRAP_RESET    = 1'b0;
  localparam logic [1:0]    CONFIG_RESET   = 2'h0;

  // =====================================================================
  // sequencer states, gray coded along reset -> sample -> run
  typedef enum logic [1:0] {
    HSP_RESET  = 2'b00,
    HSP_SAMPLE = 2'b01,
    HSP_RUN    = 2'b11
  } hsp_state_t;

endpackage

/* File: design/hsp_strap_if.sv */
`timescale 1ns/1ps
interface hsp_strap_if;
  import hsp_pkg::*;
  logic serialModeI2c;
  logic powerPolarity;
  logic gangedPower;
  logic fullAutoCharge;
  logic switchUnsupported;
  logic autoDisable;
  logic sampled;
  modport holder (output serialModeI2c, powerPolarity, gangedPower, fullAutoCharge,
                  switchUnsupported, autoDisable, sampled);
  modport user   (input serialModeI2c, powerPolarity, gangedPower, fullAutoCharge,
                  switchUnsupported, autoDisable, sampled);
endinterface

/* File: design/hsp_strap_latch.sv */
`timescale 1ns/1ps
module hsp_strap_latch
  import hsp_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      clkEn,
  input  wire logic      modePinIn,
  input  wire logic      polarityPinIn,
  input  wire logic      billboardPinIn,
  input  wire logic      config0PinIn,
  input  wire logic      config1PinIn,
  input  wire logic      chargeEnabledAny,
  input  wire logic      gangedWrite,
  input  wire logic      gangedWriteValue,
  input  wire logic      fullAutoWrite,
  input  wire logic      fullAutoWriteValue,
  input  wire logic      switchWrite,
  input  wire logic      switchWriteValue,
  input  wire logic      autoDisWrite,
  input  wire logic      autoDisWriteValue,
  hsp_strap_if.holder    straps
);

  // =====================================================================
  // sequencer and strap holding registers
  hsp_state_t state_reg, state_next;
  logic modeI2c_reg, modeI2c_next;
  logic polarity_reg, polarity_next;
  logic ganged_reg, ganged_next;
  logic fullAuto_reg, fullAuto_next;
  logic switchN_reg, switchN_next;
  logic autoDis_reg, autoDis_next;

  always_comb begin
    state_next    = state_reg;
    modeI2c_next  = modeI2c_reg;
    polarity_next = polarity_reg;
    ganged_next   = ganged_reg;
    fullAuto_next = fullAuto_reg;
    switchN_next  = switchN_reg;
    autoDis_next  = autoDis_reg;
    unique case (state_reg)
      HSP_RESET: begin
        state_next = HSP_SAMPLE;
      end
      HSP_SAMPLE: begin
        // second enabled edge after reset release takes every strap
        modeI2c_next  = modePinIn;                         // [R1]
        polarity_next = polarityPinIn;                     // [R3]
        ganged_next   = billboardPinIn;                    // [R7]
        fullAuto_next = chargeEnabledAny & config0PinIn;   // [R10]
        switchN_next  = ~chargeEnabledAny & config0PinIn;  // [R11]
        autoDis_next  = config1PinIn;                      // [R13]
        state_next    = HSP_RUN;
      end
      HSP_RUN: begin
        // values stay put except for explicit smbus overrides
        if (!modeI2c_reg) begin                            // [R15]
          if (gangedWrite) begin
            ganged_next = gangedWriteValue;                // [R7]
          end
          if (fullAutoWrite) begin
            fullAuto_next = fullAutoWriteValue;            // [R10]
          end
          if (switchWrite) begin
            switchN_next = switchWriteValue;               // [R11]
          end
          if (autoDisWrite) begin
            autoDis_next = autoDisWriteValue;              // [R13]
          end
        end
      end
      default: begin
        state_next = HSP_RESET;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg    <= HSP_RESET;
      modeI2c_reg  <= STRAP_RESET;
      polarity_reg <= STRAP_RESET;
      ganged_reg   <= STRAP_RESET;
      fullAuto_reg <= STRAP_RESET;
      switchN_reg  <= STRAP_RESET;
      autoDis_reg  <= STRAP_RESET;
    end else if (clkEn) begin
      state_reg    <= state_next;
      modeI2c_reg  <= modeI2c_next;
      polarity_reg <= polarity_next;
      ganged_reg   <= ganged_next;
      fullAuto_reg <= fullAuto_next;
      switchN_reg  <= switchN_next;
      autoDis_reg  <= autoDis_next;
    end
  end

  assign straps.serialModeI2c     = modeI2c_reg;
  assign straps.powerPolarity     = polarity_reg;
  assign straps.gangedPower       = ganged_reg;
  assign straps.fullAutoCharge    = fullAuto_reg;
  assign straps.switchUnsupported = switchN_reg;
  assign straps.autoDisable       = autoDis_reg;
  assign straps.sampled           = (state_reg == HSP_RUN);

endmodule

/* File: design/hub_strap_and_status_pins.sv */
`timescale 1ns/1ps
// Notes on behaviour
// R1: mode pin at reset release: 1 picks I2C eeprom, 0 picks SMBus slave.
// R2: with status output on, mode pin shows superspeed suspend, high means suspended.
// R3: polarity strap: 0 makes four power controls active low, 1 active high.
// R4: in I2C mode billboard pin is live input; high presents billboard, low hides.
// R5: in SMBus mode billboard enable comes from a register bit.
// R6: SMBus plus status output: billboard pin shows upstream high-speed connected.
// R7: SMBus: billboard pin strap picks individual 0 or ganged 1; host may override.
// R8: in I2C mode the two config pins give the two configured bits directly.
// R9: in SMBus mode each configured bit comes from a register.
// R10: SMBus with charging on: config pin 0 sets full-automatic bit; host may override.
// R11: SMBus charging off: config pin 0 strap, 1 means no switch support; overridable.
// R12: SMBus plus status output: config pin 0 shows upstream superspeed connected.
// R13: SMBus: config pin 1 sets the auto-disable charge bit; host may override.
// R14: SMBus plus status output: config pin 1 shows high-speed suspend, high suspended.
// R15: straps hold until reset except overrides; pins drive only after sampling.
module hub_strap_and_status_pins
  import hsp_pkg::*;
#(
  parameter int PORTS  = PORT_COUNT,
  parameter int CONFIG = CONFIG_WIDTH
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              clkEn,
  input  wire logic              statusOutputEnable,
  // multi-function pins, each split in three except the input-only polarity strap
  input  wire logic              serialModeSelectIn,
  output logic                   serialModeSelectOut,
  output logic                   serialModeSelectOe,
  input  wire logic              powerControlPolarityStrap,
  input  wire logic              billboardEnablePinIn,
  output logic                   billboardEnablePinOut,
  output logic                   billboardEnablePinOe,
  input  wire logic              billboardConfigPin0In,
  output logic                   billboardConfigPin0Out,
  output logic                   billboardConfigPin0Oe,
  input  wire logic              billboardConfigPin1In,
  output logic                   billboardConfigPin1Out,
  output logic                   billboardConfigPin1Oe,
  // hub core status
  input  wire logic              upstreamSsSuspended,
  input  wire logic              upstreamSsConnected,
  input  wire logic              upstreamHighspeedConnected,
  input  wire logic              upstreamHighspeedSuspended,
  input  wire logic [PORTS-1:0]  portPowerRequest,
  input  wire logic              chargeEnabledAny,
  // smbus register side
  input  wire logic              billboardEnableBit,
  input  wire logic [CONFIG-1:0] billboardConfigBits,
  input  wire logic              gangedWrite,
  input  wire logic              gangedWriteValue,
  input  wire logic              fullAutoWrite,
  input  wire logic              fullAutoWriteValue,
  input  wire logic              switchWrite,
  input  wire logic              switchWriteValue,
  input  wire logic              autoDisWrite,
  input  wire logic              autoDisWriteValue,
  // results
  output logic [PORTS-1:0]       portPowerControl,
  output logic                   serialModeI2c,
  output logic                   billboardEnabled,
  output logic [CONFIG-1:0]      billboardConfigured,
  output logic                   gangedPowerControl,
  output logic                   fullAutomaticChargeBit,
  output logic                   powerSwitchUnsupported,
  output logic                   chargeAutoDisableBit,
  output logic                   strapsSampled
);

  // =====================================================================
  // strap capture
  hsp_strap_if straps ();

  hsp_strap_latch u_latch (
    .clk                (clk),
    .rst                (rst),
    .clkEn              (clkEn),
    .modePinIn          (serialModeSelectIn),
    .polarityPinIn      (powerControlPolarityStrap),
    .billboardPinIn     (billboardEnablePinIn),
    .config0PinIn       (billboardConfigPin0In),
    .config1PinIn       (billboardConfigPin1In),
    .chargeEnabledAny   (chargeEnabledAny),
    .gangedWrite        (gangedWrite),
    .gangedWriteValue   (gangedWriteValue),
    .fullAutoWrite      (fullAutoWrite),
    .fullAutoWriteValue (fullAutoWriteValue),
    .switchWrite        (switchWrite),
    .switchWriteValue   (switchWriteValue),
    .autoDisWrite       (autoDisWrite),
    .autoDisWriteValue  (autoDisWriteValue),
    .straps             (straps)
  );

  // =====================================================================
  // pin muxing and status
  logic [PORTS-1:0]  pwr_reg, pwr_next;
  logic              modeOut_reg, modeOut_next, modeOe_reg, modeOe_next;
  logic              bbOut_reg, bbOut_next, bbOe_reg, bbOe_next;
  logic              c0Out_reg, c0Out_next, c0Oe_reg, c0Oe_next;
  logic              c1Out_reg, c1Out_next, c1Oe_reg, c1Oe_next;
  logic              billboard_enable_pin_reg, billboard_enable_pin_next;
  logic [CONFIG-1:0] cfg_reg, cfg_next;
  logic              i2c_reg, i2c_next;
  logic              gang_reg, gang_next;
  logic              full_reg, full_next;
  logic              sw_reg, sw_next;
  logic              autoDis_reg, autoDis_next;
  logic              smp_reg, smp_next;
  logic              smbusStatus;

  // status drive waits for held straps; smbus-only pins also need smbus mode
  function automatic logic statusDrive(
    input logic smbusOnly,
    input logic sampled,
    input logic modeI2c,
    input logic enable
  );
    return sampled & enable & ~(smbusOnly & modeI2c);
  endfunction

  always_comb begin
    // drive only once straps are held with status on; all but the mode pin also need SMBus mode
    smbusStatus  = statusDrive(1'b1, straps.sampled, straps.serialModeI2c,
                               statusOutputEnable);                             // [R15]
    modeOe_next  = statusDrive(1'b0, straps.sampled, straps.serialModeI2c,
                               statusOutputEnable);                             // [R2]
    modeOut_next = modeOe_next & upstreamSsSuspended;                          // [R2]
    bbOe_next    = smbusStatus;                                                // [R6]
    bbOut_next   = smbusStatus & upstreamHighspeedConnected;                   // [R6]
    c0Oe_next    = smbusStatus;                                                // [R12]
    c0Out_next   = smbusStatus & upstreamSsConnected;                          // [R12]
    c1Oe_next    = smbusStatus;                                                // [R14]
    c1Out_next   = smbusStatus & upstreamHighspeedSuspended;                   // [R14]
    // polarity applied to every port power control
    pwr_next = straps.powerPolarity ? portPowerRequest : ~portPowerRequest;   // [R3]
    if (straps.serialModeI2c) begin
      billboard_enable_pin_next = billboardEnablePinIn;                                        // [R4]
      cfg_next  = {billboardConfigPin1In, billboardConfigPin0In};              // [R8]
    end else begin
      billboard_enable_pin_next = billboardEnableBit;                                          // [R5]
      cfg_next  = billboardConfigBits;                                         // [R9]
    end
    if (!straps.sampled) begin
      billboard_enable_pin_next = STRAP_RESET;
      cfg_next  = CONFIG_RESET;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr_reg     <= '0;
      modeOut_reg <= 1'b0;
      modeOe_reg  <= 1'b0;
      bbOut_reg   <= 1'b0;
      bbOe_reg    <= 1'b0;
      c0Out_reg   <= 1'b0;
      c0Oe_reg    <= 1'b0;
      c1Out_reg   <= 1'b0;
      c1Oe_reg    <= 1'b0;
      billboard_enable_pin_reg    <= STRAP_RESET;
      cfg_reg     <= CONFIG_RESET;
    end else if (clkEn) begin
      pwr_reg     <= pwr_next;
      modeOut_reg <= modeOut_next;
      modeOe_reg  <= modeOe_next;
      bbOut_reg   <= bbOut_next;
      bbOe_reg    <= bbOe_next;
      c0Out_reg   <= c0Out_next;
      c0Oe_reg    <= c0Oe_next;
      c1Out_reg   <= c1Out_next;
      c1Oe_reg    <= c1Oe_next;
      billboard_enable_pin_reg    <= billboard_enable_pin_next;
      cfg_reg     <= cfg_next;
    end
  end

  // =====================================================================
  // strap mirror: held straps reach the outputs one enabled edge later
  always_comb begin
    i2c_next     = straps.serialModeI2c;                                       // [R1]
    gang_next    = straps.gangedPower;                                         // [R7]
    full_next    = straps.fullAutoCharge;                                      // [R10]
    sw_next      = straps.switchUnsupported;                                   // [R11]
    autoDis_next = straps.autoDisable;                                         // [R13]
    smp_next     = straps.sampled;                                             // [R15]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      i2c_reg     <= STRAP_RESET;
      gang_reg    <= STRAP_RESET;
      full_reg    <= STRAP_RESET;
      sw_reg      <= STRAP_RESET;
      autoDis_reg <= STRAP_RESET;
      smp_reg     <= 1'b0;
    end else if (clkEn) begin
      i2c_reg     <= i2c_next;
      gang_reg    <= gang_next;
      full_reg    <= full_next;
      sw_reg      <= sw_next;
      autoDis_reg <= autoDis_next;
      smp_reg     <= smp_next;
    end
  end

  assign portPowerControl       = pwr_reg;
  assign serialModeSelectOut    = modeOut_reg;
  assign serialModeSelectOe     = modeOe_reg;
  assign billboardEnablePinOut  = bbOut_reg;
  assign billboardEnablePinOe   = bbOe_reg;
  assign billboardConfigPin0Out = c0Out_reg;
  assign billboardConfigPin0Oe  = c0Oe_reg;
  assign billboardConfigPin1Out = c1Out_reg;
  assign billboardConfigPin1Oe  = c1Oe_reg;
  assign serialModeI2c          = i2c_reg;
  assign billboardEnabled       = billboard_enable_pin_reg;
  assign billboardConfigured    = cfg_reg;
  assign gangedPowerControl     = gang_reg;
  assign fullAutomaticChargeBit = full_reg;
  assign powerSwitchUnsupported = sw_reg;
  assign chargeAutoDisableBit   = autoDis_reg;
  assign strapsSampled          = smp_reg;

endmodule

/* File: verification/hsp_board_model.sv */
`timescale 1ns/1ps
module hsp_board_model (
  input  wire logic [3:0] strapLevel,
  input  wire logic [3:0] devOut,
  input  wire logic [3:0] devOe,
  output logic      [3:0] pinLevel
);
  // =========
  // board straps: resistors set the level while the device is not driving
  assign pinLevel = (devOe & devOut) | (~devOe & strapLevel);
endmodule

/* File: verification/hsp_monitor.sv */
`timescale 1ns/1ps
module hsp_monitor
  import hsp_pkg::*;
#(
  parameter int PORTS  = PORT_COUNT,
  parameter int CONFIG = CONFIG_WIDTH
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              clkEn,
  input wire logic              statusOutputEnable,
  input wire logic              serialModeSelectIn,
  input wire logic              serialModeSelectOe,
  input wire logic              powerControlPolarityStrap,
  input wire logic              billboardEnablePinIn,
  input wire logic              billboardEnablePinOe,
  input wire logic              billboardConfigPin0In,
  input wire logic              billboardConfigPin0Oe,
  input wire logic              billboardConfigPin1In,
  input wire logic              billboardConfigPin1Oe,
  input wire logic [PORTS-1:0]  portPowerRequest,
  input wire logic              billboardEnableBit,
  input wire logic [CONFIG-1:0] billboardConfigBits,
  input wire logic [PORTS-1:0]  portPowerControl,
  input wire logic              serialModeI2c,
  input wire logic              billboardEnabled,
  input wire logic [CONFIG-1:0] billboardConfigured,
  input wire logic              gangedPowerControl,
  input wire logic              strapsSampled
);
  // =========
  // polarity pin as last seen before strapsSampled rose
  logic polSeen_reg;
  logic polSeen_next;
  always_comb polSeen_next = (clkEn && !strapsSampled) ? powerControlPolarityStrap : polSeen_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) polSeen_reg <= 1'b0;
    else polSeen_reg <= polSeen_next;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence relSeq;
    $past(rst) && clkEn ##1 clkEn ##1 clkEn;
  endsequence
  sequence steady;
    strapsSampled && $past(strapsSampled) && $past(clkEn);
  endsequence
  start_seq_a: assert property (relSeq |-> !strapsSampled ##1 strapsSampled)
    else $error("straps not sampled on time");
  no_drive_a: assert property (!strapsSampled |-> !(serialModeSelectOe ||
    billboardEnablePinOe || billboardConfigPin0Oe || billboardConfigPin1Oe))
    else $error("pin driven before sampling");
  mode_strap_a: assert property ($rose(strapsSampled) |->
    serialModeI2c == $past(serialModeSelectIn, 2)) else $error("serial mode strap wrong");
  straps_hold_a: assert property (steady |-> $stable(serialModeI2c) &&
    (!serialModeI2c || $stable(gangedPowerControl))) else $error("strap value moved");
  power_follow_a: assert property (steady |-> portPowerControl ==
    (polSeen_reg ? $past(portPowerRequest) : ~$past(portPowerRequest)))
    else $error("power control polarity wrong");
  pin_enable_a: assert property (steady |-> serialModeSelectOe == $past(statusOutputEnable)
    && billboardEnablePinOe == ($past(statusOutputEnable) && !serialModeI2c)
    && billboardConfigPin0Oe == billboardEnablePinOe
    && billboardConfigPin1Oe == billboardEnablePinOe) else $error("pin enable wrong");
  config_src_a: assert property (steady |-> billboardConfigured == (serialModeI2c ?
    {$past(billboardConfigPin1In), $past(billboardConfigPin0In)} : $past(billboardConfigBits)))
    else $error("configured bits wrong");
  bb_source_a: assert property (steady |-> billboardEnabled == (serialModeI2c ?
    $past(billboardEnablePinIn) : $past(billboardEnableBit))) else $error("billboard wrong");
endmodule
bind hub_strap_and_status_pins hsp_monitor #(.PORTS(PORTS), .CONFIG(CONFIG)) u_hsp_monitor (.*);

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       clkEn = 1'b1;
  logic       stsEn = 1'b1;
  logic       pol = 1'b0;
  logic       chg = 1'b0;
  logic       bbBit = 1'b0;
  logic [1:0] cfgBits = 2'h0;
  logic [3:0] strap = 4'h0;
  logic [3:0] stat = 4'ha;
  logic [3:0] req = 4'h5;
  logic [3:0] wrs = 4'h0;
  logic [3:0] wrv = 4'h0;
  wire  [3:0] pinIn, pinOut, pinOe, ppc;
  logic [1:0] bbCfg;
  logic       i2c, billboard_enable_pin, ganged, fullAuto, swUns, autoDis, sampled;
  int         numErrors = 0;
  int         nChecks = 0;
  hsp_board_model u_hsp_board_model (.strapLevel(strap), .devOut(pinOut), .devOe(pinOe),
    .pinLevel(pinIn));
  hub_strap_and_status_pins u_hub_strap_and_status_pins (.clk(clk), .rst(rst), .clkEn(clkEn),
    .statusOutputEnable(stsEn), .powerControlPolarityStrap(pol),
    .serialModeSelectIn(pinIn[0]), .serialModeSelectOut(pinOut[0]), .serialModeSelectOe(pinOe[0]),
    .billboardEnablePinIn(pinIn[1]), .billboardEnablePinOut(pinOut[1]),
    .billboardEnablePinOe(pinOe[1]), .billboardConfigPin0In(pinIn[2]),
    .billboardConfigPin0Out(pinOut[2]), .billboardConfigPin0Oe(pinOe[2]),
    .billboardConfigPin1In(pinIn[3]), .billboardConfigPin1Out(pinOut[3]),
    .billboardConfigPin1Oe(pinOe[3]), .upstreamSsSuspended(stat[0]),
    .upstreamHighspeedConnected(stat[1]), .upstreamSsConnected(stat[2]),
    .upstreamHighspeedSuspended(stat[3]), .portPowerRequest(req), .chargeEnabledAny(chg),
    .billboardEnableBit(bbBit), .billboardConfigBits(cfgBits), .gangedWrite(wrs[0]),
    .gangedWriteValue(wrv[0]), .fullAutoWrite(wrs[1]), .fullAutoWriteValue(wrv[1]),
    .switchWrite(wrs[2]), .switchWriteValue(wrv[2]), .autoDisWrite(wrs[3]),
    .autoDisWriteValue(wrv[3]), .portPowerControl(ppc), .serialModeI2c(i2c),
    .billboardEnabled(billboard_enable_pin), .billboardConfigured(bbCfg), .gangedPowerControl(ganged),
    .fullAutomaticChargeBit(fullAuto), .powerSwitchUnsupported(swUns),
    .chargeAutoDisableBit(autoDis), .strapsSampled(sampled));
  initial begin
    forever #5 clk = ~clk;
  end
  // =========
  // access tasks
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic boot(input logic [3:0] s, input logic p, input logic c);
    @(posedge clk);
    rst <= 1'b1;
    strap <= s;
    pol <= p;
    chg <= c;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 20 && sampled !== 1'b1; i++) settle(1);
    settle(1);
    cmp(sampled, 8'h01);
  endtask
  task automatic wr(input logic [3:0] v);
    @(posedge clk);
    wrs <= 4'hf;
    wrv <= v;
    @(posedge clk);
    wrs <= 4'h0;
    settle(3);
  endtask
  task automatic closeOut;
    $display("checks %0d mismatches %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #20000;
    numErrors++;
    closeOut();
  end
  // =========
  // tests
  initial begin
    boot(4'h7, 1'b0, 1'b0);
    cmp(i2c, 8'h01);
    cmp(ppc, 8'h0a);
    cmp(billboard_enable_pin, 8'h01);
    cmp(bbCfg, 8'h01);
    cmp({pinOut[0], pinOe}, 8'h01);
    @(posedge clk);
    strap <= 4'h1;
    pol <= 1'b1;
    stat <= 4'hb;
    settle(2);
    cmp(billboard_enable_pin, 8'h00);
    cmp(bbCfg, 8'h00);
    cmp(ppc, 8'h0a);
    cmp(pinOut[0], 8'h01);
    wr(4'hf);
    cmp({ganged, fullAuto, swUns, autoDis}, 8'h0a);
    $display("test 1 done");
    @(posedge clk);
    bbBit <= 1'b1;
    cfgBits <= 2'h2;
    stat <= 4'h3;
    boot(4'he, 1'b1, 1'b1);
    cmp(i2c, 8'h00);
    cmp(ganged, 8'h01);
    cmp(fullAuto, 8'h01);
    cmp(autoDis, 8'h01);
    cmp({billboard_enable_pin, bbCfg}, 8'h06);
    cmp(ppc, 8'h05);
    cmp({pinOut, pinOe}, 8'h3f);
    @(posedge clk);
    bbBit <= 1'b0;
    cfgBits <= 2'h1;
    stat <= 4'hc;
    settle(2);
    cmp({billboard_enable_pin, bbCfg}, 8'h01);
    cmp(pinOut, 8'h0c);
    wr(4'h4);
    cmp({ganged, fullAuto, swUns, autoDis}, 8'h02);
    $display("test 2 done");
    boot(4'h4, 1'b0, 1'b0);
    cmp({ganged, fullAuto, swUns, autoDis}, 8'h02);
    @(posedge clk);
    clkEn <= 1'b0;
    req <= 4'h3;
    settle(3);
    cmp(ppc, 8'h0a);
    @(posedge clk);
    clkEn <= 1'b1;
    stsEn <= 1'b0;
    settle(2);
    cmp(ppc, 8'h0c);
    cmp({pinOut, pinOe}, 8'h00);
    $display("test 3 done");
    closeOut();
  end
endmodule
